// >>> rtl/rst_pd_ctrl.sv
// module: reset sequencing and power-down control top
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rst_pd_ctrl
  import rst_pd_pkg::*;
#(
  parameter int prescale = bit_prescale
) (
  input wire logic clock, // system clock, 200 MHz
  input wire logic srst, // synchronous reset, active high
  input wire logic [7:0] addr, // register address
  input wire logic [7:0] wdata, // register write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  input wire logic reset_pin_n, // external reset pin
  input wire logic ext_reset_en, // external reset function enable
  input wire logic watchdog_timeout, // watchdog reset request
  input wire logic power_rise, // power-on detector output
  input wire logic supply_drop, // low voltage detector output
  input wire logic oscillator_select_option, // option: osc mode
  input wire logic low_voltage_reset_option_enable, // option
  input wire logic stop_exec, // cpu executes stop instruction
  input wire logic irq_wake, // enabled interrupt pending
  input wire logic global_irq_flag, // cpu interrupt enable flag
  input wire logic [15:0] cpu_pc, // pc of next instruction
  output logic [15:0] vec_addr, // vector fetch address
  output logic vec_rd, // vector fetch strobe
  input wire logic [7:0] vec_data, // vector byte, next cycle
  output logic [15:0] pc_load, // pc value to load
  output logic pc_load_en, // load pc pulse
  output logic cpu_halt, // cpu stopped
  output logic cpu_rst, // cpu and registers held in reset
  output logic clk_gate_en, // system and peripheral clocks on
  output logic irq_vector, // take interrupt on wake pulse
  output logic irq_continue, // continue without vector pulse
  output logic [7:0] ram_page_pointer, // ram page register
  output logic direct_page_flag, // direct page flag
  output logic osc_mode, // latched oscillator mode
  output logic lvr_en // latched supply drop reset enable
);
  // -------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------
  logic [1:0] pin_s, por_s, lvd_s;
  logic pin_q;
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_s <= 2'b11;
      por_s <= 2'b00;
      lvd_s <= 2'b00;
      pin_q <= 1'b1;
    end else begin
      pin_s <= {pin_s[0], reset_pin_n};
      por_s <= {por_s[0], power_rise};
      lvd_s <= {lvd_s[0], supply_drop};
      pin_q <= pin_s[1];
    end
  end
  logic por_q, lvd_q;
  always_ff @(posedge clock) begin
    if (srst) begin
      por_q <= 1'b0;
      lvd_q <= 1'b0;
    end else begin
      por_q <= por_s[1];
      lvd_q <= lvd_s[1];
    end
  end
  // -------------------------------------------------
  // registers
  // -------------------------------------------------
  logic [7:0] power_on_reset_disable_key;
  logic [7:0] power_down_entry_key;
  logic stop_armed;
  logic por_enabled;
  assign por_enabled = (power_on_reset_disable_key != por_disable_code);
  // source events: pin rising edge after low, detector rising edges
  logic ev_pin, ev_por, ev_lvr, ev_any;
  assign ev_pin = ext_reset_en && pin_s[1] && !pin_q;
  assign ev_por = por_enabled && por_s[1] && !por_q;
  assign ev_lvr = lvr_en && !por_enabled && lvd_s[1] && !lvd_q;
  assign ev_any = ev_pin || ev_por || ev_lvr || watchdog_timeout;
  // decode of the register port
  logic wr_por, wr_pd, sleep_req, stop_req;
  assign wr_por = wr && (addr == por_key_addr);
  assign wr_pd = wr && (addr == pd_key_addr);
  assign sleep_req = wr_pd && (wdata == sleep_code);
  // stop only after a 5A write with no other bus write since, the write cycle itself excluded
  assign stop_req = stop_exec && stop_armed;
  // -------------------------------------------------
  // sequencer
  // -------------------------------------------------
  seq_state_t state, next_state;
  stab_if sif();
  stab_timer #(.prescale(prescale)) u_timer (
    .clock(clock),
    .srst(srst),
    .tif(sif)
  );
  logic [2:0] init_cnt;
  logic wake_irq;
  assign wake_irq = ((state == st_sleep) || (state == st_stop)) && irq_wake;
  // timer restarts on every reset event and on wake-up
  assign sif.start = ev_any || wake_irq;
  always_comb begin
    next_state = state;
    unique case (state)
      st_stab: if (sif.done) next_state = st_init;
      st_init: if (init_cnt == 3'(init_cycles - 1)) next_state = st_run;
      st_run: begin
        if (stop_req) next_state = st_stop;
        else if (sleep_req) next_state = st_sleep;
      end
      // wake passes through the stabilization count
      st_sleep: if (irq_wake) next_state = st_stab;
      st_stop: if (irq_wake) next_state = st_stab;
      default: next_state = st_stab;
    endcase
    if (ev_any) next_state = st_stab;
  end
  // remember whether the wait belongs to a reset or a wake-up
  logic from_reset, from_stop;
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= st_stab;
      from_reset <= 1'b1;
      from_stop <= 1'b0;
    end else begin
      state <= next_state;
      if (ev_any) from_reset <= 1'b1;
      else if (wake_irq) from_reset <= 1'b0;
      if (ev_any) from_stop <= 1'b0;
      else if (wake_irq) from_stop <= (state == st_stop);
    end
  end
  // -------------------------------------------------
  // initialization phase and vector fetch
  // -------------------------------------------------
  logic in_init;
  assign in_init = (state == st_init) && from_reset;
  always_ff @(posedge clock) begin
    if (srst || state != st_init) begin
      init_cnt <= 3'h0;
    end else begin
      init_cnt <= init_cnt + 3'h1;
    end
  end
  // cycle 0 fetches high byte, cycle 1 low byte
  assign vec_rd = in_init && (init_cnt < 3'h2);
  assign vec_addr = (init_cnt == 3'h0) ? vector_hi_addr : vector_lo_addr;
  logic [15:0] next_pc;
  always_ff @(posedge clock) begin
    if (srst) begin
      next_pc <= 16'h0000;
    end else if (in_init && init_cnt == 3'h1) begin
      next_pc[15:8] <= vec_data;
    end else if (in_init && init_cnt == 3'h2) begin
      next_pc[7:0] <= vec_data;
    end
  end
  // -------------------------------------------------
  // outputs to cpu
  // -------------------------------------------------
  logic init_end, wake_end;
  assign init_end = (state == st_init) && (next_state == st_run);
  assign wake_end = init_end && !from_reset;
  always_ff @(posedge clock) begin
    if (srst) begin
      pc_load <= 16'h0000;
      pc_load_en <= 1'b0;
      irq_vector <= 1'b0;
      irq_continue <= 1'b0;
    end else begin
      pc_load <= from_reset ? next_pc : cpu_pc;
      pc_load_en <= init_end && from_reset;
      irq_vector <= wake_end && global_irq_flag;
      irq_continue <= wake_end && !global_irq_flag;
    end
  end
  // registers held only while reset sequence runs, not on wake
  assign cpu_rst = (state == st_stab || state == st_init) && from_reset;
  assign cpu_halt = (state != st_run);
  assign clk_gate_en = (state != st_stop);
  // -------------------------------------------------
  // control registers
  // -------------------------------------------------
  // ram itself is outside; only control state is reinitialized
  always_ff @(posedge clock) begin
    if (srst || ev_any) begin
      power_on_reset_disable_key <= por_key_reset;
      ram_page_pointer <= ram_page_reset;
      direct_page_flag <= 1'b0;
    end else if (wr_por) begin
      power_on_reset_disable_key <= wdata;
    end
  end
  // entry key: cleared on leaving stop
  always_ff @(posedge clock) begin
    if (srst || ev_any) begin
      power_down_entry_key <= pd_key_reset;
      stop_armed <= 1'b0;
    end else if (state == st_stop && irq_wake) begin
      power_down_entry_key <= pd_key_reset;
      stop_armed <= 1'b0;
    end else begin
      if (wr_pd) power_down_entry_key <= wdata;
      // any other bus write cancels the arm; instructions do not
      stop_armed <= wr_pd ? (wdata == stop_code) : (stop_armed && !wr);
    end
  end
  // options are taken while the reset sequence runs
  always_ff @(posedge clock) begin
    if (srst) begin
      osc_mode <= 1'b0;
      lvr_en <= 1'b0;
    end else if (state == st_init && from_reset) begin
      osc_mode <= oscillator_select_option;
      lvr_en <= low_voltage_reset_option_enable;
    end
  end
  // -------------------------------------------------
  // read port
  // -------------------------------------------------
  logic [7:0] rd_mux;
  assign rd_mux = (addr == por_key_addr) ? power_on_reset_disable_key :
                  (addr == status_addr) ? {3'h0, state} :
                  (addr == pc_addr_lo) ? next_pc[7:0] :
                  (addr == pc_addr_hi) ? next_pc[15:8] : 8'h00;
  always_ff @(posedge clock) begin
    if (srst) rdata <= 8'h00;
    else rdata <= rd ? rd_mux : 8'h00;
  end
  // -------------------------------------------------
  // checks
  // -------------------------------------------------
  stab_wait_a: assert property (@(posedge clock) disable iff (srst)
    (state == st_stab && !sif.done) |=> state == st_stab || ev_any)
    else $error("left stabilization before timer overflow");
  init_len_a: assert property (@(posedge clock) disable iff (srst)
    ($rose(state == st_init) && !ev_any) |->
      (state == st_init)[*6] ##1 (state == st_run || ev_any || state == st_stab))
    else $error("initialization not six cycles");
  vec_order_a: assert property (@(posedge clock) disable iff (srst)
    (vec_rd && vec_addr == vector_hi_addr) |=> vec_addr == vector_lo_addr)
    else $error("vector bytes fetched out of order");
  // watch the state, not ev_lvr itself, so a broken mask is caught
  por_mask_a: assert property (@(posedge clock) disable iff (srst)
    (state == st_run && por_enabled && lvd_s[1] && !lvd_q && !ev_pin &&
     !ev_por && !watchdog_timeout && !sleep_req && !stop_req)
      |=> state == st_run)
    else $error("supply drop reset while power-on reset enabled");
  bad_code_a: assert property (@(posedge clock) disable iff (srst)
    (state == st_run && wr_pd && wdata != sleep_code && !stop_req && !ev_any)
      |=> state == st_run)
    else $error("power-down entered on wrong code");
  sleep_entry_a: assert property (@(posedge clock) disable iff (srst)
    (state == st_run && sleep_req && !stop_req && !ev_any) |=> cpu_halt)
    else $error("sleep write did not halt cpu");
  stop_clr_a: assert property (@(posedge clock) disable iff (srst)
    (state == st_stop && irq_wake) |=> power_down_entry_key == pd_key_reset)
    else $error("entry key not cleared on stop release");
  stop_gate_a: assert property (@(posedge clock) disable iff (srst)
    (state == st_run && stop_req && !ev_any) |=> !clk_gate_en)
    else $error("clocks not gated in stop");
  wake_irq_a: assert property (@(posedge clock) disable iff (srst)
    irq_vector |-> !irq_continue && !$past(from_reset))
    else $error("wake-up vector decision wrong");
  wake_restart_a: assert property (@(posedge clock) disable iff (srst)
    wake_irq |=> sif.count == bit_start && state == st_stab)
    else $error("wake-up did not restart the interval timer");
endmodule
`default_nettype wire

// >>> rtl/rst_pd_pkg.sv
// package: constants for the reset and power-down controller
package rst_pd_pkg;
  // register map, byte addresses on the register port
  localparam logic [7:0] por_key_addr = 8'hF3;
  localparam logic [7:0] pd_key_addr = 8'hF5;
  localparam logic [7:0] status_addr = 8'hF6;
  localparam logic [7:0] pc_addr_lo = 8'hF7;
  localparam logic [7:0] pc_addr_hi = 8'hF8;
  // reset values
  localparam logic [7:0] por_key_reset = 8'h00;
  localparam logic [7:0] pd_key_reset = 8'h00;
  // key codes
  localparam logic [7:0] por_disable_code = 8'h5A;
  localparam logic [7:0] sleep_code = 8'h0F;
  localparam logic [7:0] stop_code = 8'h5A;
  // vector addresses, high byte at the top address
  localparam logic [15:0] vector_hi_addr = 16'hFFFF;
  localparam logic [15:0] vector_lo_addr = 16'hFFFE;
  // timing: interval timer runs 00..FF at fxin/1024
  localparam int bit_prescale = 1024;
  localparam logic [7:0] bit_start = 8'h00;
  localparam logic [7:0] bit_full = 8'hFF;
  localparam int init_cycles = 6;
  localparam logic [7:0] ram_page_reset = 8'h00;
  // sequencer states, one-hot
  typedef enum logic [4:0] {
    st_stab = 5'h01,
    st_init = 5'h02,
    st_run = 5'h04,
    st_sleep = 5'h08,
    st_stop = 5'h10
  } seq_state_t;
endpackage

// >>> rtl/stab_if.sv
// interface: between sequencer and stabilization timer
`timescale 1ns/1ps
`default_nettype none
interface stab_if;
  logic start; // restart count from zero
  logic done; // one-cycle pulse on overflow past full
  logic [7:0] count; // current timer value
  modport ctrl (output start, input done, count);
  modport timer (input start, output done, count);
endinterface
`default_nettype wire

// >>> rtl/stab_timer.sv
// module: basic interval timer used as stabilization counter
`timescale 1ns/1ps
`default_nettype none
module stab_timer
  import rst_pd_pkg::*;
#(
  parameter int prescale = bit_prescale
) (
  input wire logic clock, // system clock
  input wire logic srst, // synchronous reset, active high
  stab_if.timer tif // control from sequencer
);
  logic [10:0] div;
  logic tick;
  logic [7:0] count;
  logic done;
  assign tick = (div == 11'(prescale - 1));
  assign tif.count = count;
  assign tif.done = done;
  // -------------------------------------------------
  // prescaler and 8-bit counter
  // -------------------------------------------------
  // restart wins over a pending tick so the count truly starts at zero
  always_ff @(posedge clock) begin
    if (srst || tif.start) begin
      div <= 11'h000;
      count <= bit_start;
      done <= 1'b0;
    end else begin
      div <= tick ? 11'h000 : div + 11'h001;
      done <= tick && (count == bit_full);
      if (tick) begin
        count <= count + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/reset_and_power_down_control_test.sv
// testbench: register-port and event sequences for the reset controller
`timescale 1ns/1ps
`default_nettype none
module reset_and_power_down_control_test;
  import rst_pd_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  localparam int pre = 2; // short prescale keeps each sequence near 520 cycles
  localparam logic [15:0] vec = 16'hC3A5;
  logic clock = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, vec_data = 8'h00;
  logic reset_pin_n = 1'b1, ext_reset_en = 1'b0, watchdog_timeout = 1'b0;
  logic power_rise = 1'b0, supply_drop = 1'b0, osc_opt = 1'b1;
  logic lvr_opt = 1'b1;
  logic stop_exec = 1'b0, irq_wake = 1'b0, global_irq_flag = 1'b0;
  logic [15:0] vec_addr, pc_load;
  logic vec_rd, pc_load_en, cpu_halt, cpu_rst, clk_gate_en, irq_vector;
  logic irq_continue, direct_page_flag, osc_mode, lvr_en;
  logic [7:0] ram_page_pointer;
  int failures = 0, compares = 0, n;
  always #2.5 clock = ~clock;
  // vector memory answers one cycle after the fetch strobe
  always @(posedge clock) begin
    if (vec_rd === 1'b1) begin
      vec_data <= vec_addr === 16'hFFFF ? vec[15:8] :
                  vec_addr === 16'hFFFE ? vec[7:0] : 8'h3C;
    end else begin
      vec_data <= ~vec_data; // stale bytes toggle every cycle instead of holding
    end
  end
  rst_pd_ctrl #(.prescale(pre)) dut_u (
    .clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .reset_pin_n(reset_pin_n),
    .ext_reset_en(ext_reset_en), .watchdog_timeout(watchdog_timeout),
    .power_rise(power_rise), .supply_drop(supply_drop),
    .oscillator_select_option(osc_opt),
    .low_voltage_reset_option_enable(lvr_opt), .stop_exec(stop_exec),
    .irq_wake(irq_wake), .global_irq_flag(global_irq_flag),
    .cpu_pc(16'h1234), .vec_addr(vec_addr), .vec_rd(vec_rd),
    .vec_data(vec_data), .pc_load(pc_load), .pc_load_en(pc_load_en),
    .cpu_halt(cpu_halt), .cpu_rst(cpu_rst), .clk_gate_en(clk_gate_en),
    .irq_vector(irq_vector), .irq_continue(irq_continue),
    .ram_page_pointer(ram_page_pointer),
    .direct_page_flag(direct_page_flag), .osc_mode(osc_mode),
    .lvr_en(lvr_en));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (failures == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, exp});
  endtask
  // sel 0 pc load, 1 vectored wake, 2 plain wake; bounded search
  task automatic wait_evt(input int sel, output int cnt);
    logic hit;
    hit = 1'b0;
    cnt = 0;
    while (cnt < 2000 && !hit) begin
      @(posedge clock);
      #1;
      cnt++;
      hit = sel == 0 ? pc_load_en === 1'b1 :
            sel == 1 ? irq_vector === 1'b1 : irq_continue === 1'b1;
    end
    if (!hit) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, 0, 1);
      end_sim();
    end
  endtask
  task automatic seq_done();
    wait_evt(0, n);
    chk(pc_load, vec);
    idle(2);
  endtask
  // a reset event shows as cpu_rst within ten cycles, or not at all
  task automatic chk_rst(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (10) begin
      @(posedge clock);
      #1;
      seen = seen | (cpu_rst === 1'b1);
    end
    chk({15'h0, seen}, {15'h0, exp});
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    idle(8);
    srst <= 1'b0;
    rd_reg(status_addr, 8'h01);
    rd_reg(por_key_addr, por_key_reset);
    rd_reg(pd_key_addr, 8'h00);
    rd_reg(8'h10, 8'h00);
    wait_evt(0, n);
    n = n + 8; // the four reads above spent eight edges after release
    chk({15'h0, n >= 256 * pre + 6 && n <= 256 * pre + 14}, 16'h1);
    chk(pc_load, vec);
    chk({ram_page_pointer, 7'h0, direct_page_flag}, 16'h0);
    chk({14'h0, osc_mode, lvr_en}, 16'h3);
    idle(2);
    rd_reg(status_addr, 8'h04);
    rd_reg(pc_addr_lo, vec[7:0]);
    rd_reg(pc_addr_hi, vec[15:8]);
    // near-miss key keeps power-on reset armed; reset clears the key
    wr_reg(por_key_addr, 8'h5B);
    rd_reg(por_key_addr, 8'h5B);
    power_rise <= 1'b1;
    chk_rst(1'b1);
    power_rise <= 1'b0;
    seq_done();
    rd_reg(por_key_addr, 8'h00);
    wr_reg(por_key_addr, por_disable_code);
    power_rise <= 1'b1;
    chk_rst(1'b0);
    supply_drop <= 1'b1;
    chk_rst(1'b1);
    supply_drop <= 1'b0;
    seq_done();
    idle(3);
    supply_drop <= 1'b1;
    chk_rst(1'b0);
    supply_drop <= 1'b0;
    // watchdog reset takes the new option levels
    osc_opt <= 1'b0;
    lvr_opt <= 1'b0;
    watchdog_timeout <= 1'b1;
    idle(1);
    watchdog_timeout <= 1'b0;
    chk_rst(1'b1);
    seq_done();
    chk({14'h0, osc_mode, lvr_en}, 16'h0);
    // option off: a drop with power-on reset disabled does nothing
    wr_reg(por_key_addr, por_disable_code);
    supply_drop <= 1'b1;
    chk_rst(1'b0);
    supply_drop <= 1'b0;
    // the pin counts only while the function is enabled
    reset_pin_n <= 1'b0;
    idle(4);
    reset_pin_n <= 1'b1;
    chk_rst(1'b0);
    ext_reset_en <= 1'b1;
    reset_pin_n <= 1'b0;
    idle(4);
    reset_pin_n <= 1'b1;
    chk_rst(1'b1);
    seq_done();
    // stray codes, bare stop and a cancelled arm enter nothing
    wr_reg(por_key_addr, 8'h77);
    wr_reg(pd_key_addr, 8'h11);
    chk({14'h0, cpu_halt, clk_gate_en}, 16'h1);
    stop_exec <= 1'b1;
    idle(1);
    stop_exec <= 1'b0;
    #1 chk({15'h0, clk_gate_en}, 16'h1);
    wr_reg(pd_key_addr, stop_code);
    wr_reg(por_key_addr, 8'h77);
    stop_exec <= 1'b1;
    idle(1);
    stop_exec <= 1'b0;
    #1 chk({15'h0, clk_gate_en}, 16'h1);
    // sleep, then vectored and plain interrupt wake
    global_irq_flag <= 1'b1;
    wr_reg(pd_key_addr, sleep_code);
    chk({14'h0, cpu_halt, clk_gate_en}, 16'h3);
    idle(1);
    rd_reg(status_addr, 8'h08);
    irq_wake <= 1'b1;
    wait_evt(1, n);
    irq_wake <= 1'b0;
    chk({15'h0, n >= 256 * pre && n <= 256 * pre + 14}, 16'h1);
    chk({15'h0, irq_continue}, 16'h0);
    rd_reg(por_key_addr, 8'h77);
    chk({7'h0, ram_page_pointer, cpu_halt}, 16'h0);
    global_irq_flag <= 1'b0;
    wr_reg(pd_key_addr, sleep_code);
    irq_wake <= 1'b1;
    wait_evt(2, n);
    irq_wake <= 1'b0;
    chk({15'h0, irq_vector}, 16'h0);
    // stop: gated clocks, wake, then the key is spent
    wr_reg(pd_key_addr, stop_code);
    stop_exec <= 1'b1;
    idle(1);
    stop_exec <= 1'b0;
    #1 chk({14'h0, cpu_halt, clk_gate_en}, 16'h2);
    irq_wake <= 1'b1;
    wait_evt(2, n);
    irq_wake <= 1'b0;
    idle(2);
    chk({14'h0, cpu_halt, clk_gate_en}, 16'h1);
    chk(pc_load, 16'h1234);
    rd_reg(por_key_addr, 8'h77);
    stop_exec <= 1'b1;
    idle(1);
    stop_exec <= 1'b0;
    #1 chk({15'h0, clk_gate_en}, 16'h1);
    // sleep left by a reset runs the full sequence
    wr_reg(pd_key_addr, sleep_code);
    watchdog_timeout <= 1'b1;
    idle(1);
    watchdog_timeout <= 1'b0;
    chk_rst(1'b1);
    seq_done();
    rd_reg(por_key_addr, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
